// *** include/int_prio_pkg.sv ***
// constants and types for the interrupt software priority controller
package int_prio_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_VEC   = 14;
  localparam int VEC_W     = 4;
  localparam int ADDR_W    = 4;
  localparam int STACK_D   = 4;
  localparam int STACK_W   = 2;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_PRIO0  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_PRIO1  = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_PRIO2  = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_PRIO3  = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_MASK   = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_RSTSRC = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_STATE  = 4'h8;

  // ****************************************
  // reset values and field layout
  // ****************************************
  localparam logic [7:0] PRIO_RST      = 8'hFF;
  localparam logic [7:0] PRIO3_RO_MASK = 8'hF0;
  localparam logic [7:0] ZERO8         = 8'h00;
  localparam int         CTRL_WARN_EN  = 0;
  localparam int         ST_WARN       = 0;
  localparam int         ST_REJECT     = 1;
  localparam int         ST_REENTRY    = 2;
  localparam int         ST_W          = 3;

  // level codes: same encoding as the condition-code level bits
  localparam logic [1:0] LVL_0 = 2'h2;
  localparam logic [1:0] LVL_1 = 2'h1;
  localparam logic [1:0] LVL_2 = 2'h0;
  localparam logic [1:0] LVL_3 = 2'h3;

  // ****************************************
  // sources
  // ****************************************
  localparam logic [VEC_W-1:0]   WARN_VEC       = 4'h1;
  localparam logic [NUM_VEC-1:0] HALT_WAKE_MASK = 14'h003D;

  // ****************************************
  // timing: reset delay in cpu cycles
  // ****************************************
  localparam logic [12:0] DELAY_SHORT = 13'h0100;
  localparam logic [12:0] DELAY_LONG  = 13'h1000;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       interrupts_enable_instr;
    logic       sim;
    logic       halt;
    logic       wait_for_interrupt_instr;
    logic       interrupt_return_instr;
    logic       pop;
    logic       trap;
    logic       ack;
    logic [1:0] pop_level;
  } core_op_t;

  typedef struct packed {
    logic             req;
    logic [VEC_W-1:0] vec;
    logic [1:0]       level;
  } int_req_t;

  typedef enum logic [1:0] {RUN, WAITING, HALTED} pmode_t;

endpackage : int_prio_pkg

// *** rtl/int_prio_ctrl.sv ***
// interrupt software priority controller with supply-warning source
// Functional notes
// RL1: each vector except reset and trap owns a two-bit field, vector 0 to 13.
// RL2: field codes use the same level encoding as condition-code level bits.
// RL3: writing level-0 pattern into a field is ignored; other fields still update.
// RL4: trap or reset sets both condition-code level bits to one.
// RL5: raising a running, still pending vector's priority re-enters it.
// RL6: otherwise the active priority holds until the next request after return.
// RL7: entry saves the level and loads the vector priority; pop restores it.
// RL8: enable, disable, halt, wait, return and pop instructions also set the level.
// RL9: supply warning interrupts only when enabled and level mask is clear; O_IRQ takes the warn flag through mask_r alone.
// RL10: supply warning wakes from wait mode, never from halt mode.
// RL11: reset-source status register is frozen while halted.
// RL12: supply rise quicker than the reset delay raises no warning.
// RL13: early enable on a slow rise gives two warnings, at enable and threshold.
// RL14: enable after the threshold on a slow rise gives exactly one warning.
// RL15: only a fixed subset of vectors may wake the device from halt.
// RL16: service only above current level; ties go to the lowest vector number.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module int_prio_ctrl (
  input  wire logic                               I_CLOCK,
  input  wire logic                               I_RST_N,
  input  wire logic [int_prio_pkg::ADDR_W-1:0]    I_ADDR,
  input  wire logic [7:0]                         I_WDATA,
  input  wire logic                               I_WR,
  input  wire logic                               I_RD,
  output logic      [7:0]                         O_RDATA,
  input  wire logic [int_prio_pkg::NUM_VEC-1:0]   I_IRQ,
  input  wire logic                               I_WARN_EVENT,
  input  wire logic                               I_LONG_DELAY,
  input  wire logic [7:0]                         I_RST_SRC,
  input  wire int_prio_pkg::core_op_t             I_CORE_OP,
  output int_prio_pkg::int_req_t                  O_INT,
  output logic      [1:0]                         O_CC_LEVEL,
  output logic                                    O_WAKE,
  output logic                                    O_IRQ
);
  import int_prio_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  // rank of a level code, 0 lowest .. 3 masked
  function automatic logic [1:0] rank(input logic [1:0] lv);
    unique case (lv)
      LVL_0:   rank = 2'h0;
      LVL_1:   rank = 2'h1;
      LVL_2:   rank = 2'h2;
      default: rank = 2'h3;
    endcase
  endfunction : rank

  // merge a write into a priority byte, skipping forbidden fields
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd);
    logic [7:0] res;
    res = old;
    for (int f = 0; f < 4; f++) begin
      if (wd[2*f +: 2] != LVL_0) begin
        res[2*f +: 2] = wd[2*f +: 2]; // RL3
      end
    end
    return res;
  endfunction : merge

  function automatic logic has_reject(input logic [7:0] wd, input int nf);
    logic r;
    r = 1'b0;
    for (int f = 0; f < 4; f++) begin
      if (f < nf && wd[2*f +: 2] == LVL_0) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction : has_reject

  // ****************************************
  // state
  // ****************************************
  logic [7:0]         prio_r [4];
  logic [1:0]         eff_r [NUM_VEC];
  logic [NUM_VEC-1:0] active_r;
  logic [VEC_W-1:0]   stack_r [STACK_D];
  logic [STACK_W:0]   sp_r;
  logic [1:0]         cc_r;
  pmode_t             mode_r;
  logic               warn_en_r;
  logic [ST_W-1:0]    status_r;
  logic [ST_W-1:0]    mask_r;
  logic [7:0]         rst_src_r;
  logic [12:0]        dly_cnt_r;
  int_req_t           int_r;
  logic [7:0]         rdata_r;

  logic [1:0]         field    [NUM_VEC];
  logic [NUM_VEC-1:0] pend;
  logic [NUM_VEC-1:0] raise;
  logic               win_req;
  logic [VEC_W-1:0]   win_vec;
  logic [1:0]         win_lvl;
  logic               reject_ev;
  logic               reentry_ev;
  logic               warn_ev;
  logic               delay_done;
  logic [12:0]        delay_lim;
  logic               do_ack;
  logic               do_ret;
  logic [VEC_W-1:0]   top_vec;

  // ****************************************
  // field decode and pending sources
  // ****************************************
  // the warning flag doubles as the pending request of its vector
  always_comb begin
    for (int v = 0; v < NUM_VEC; v++) begin
      field[v] = prio_r[v / 4][2*(v % 4) +: 2]; // RL1
      pend[v]  = I_IRQ[v];
    end
    pend[WARN_VEC] = I_IRQ[WARN_VEC] | (status_r[ST_WARN] & warn_en_r); // RL9
  end

  // raising fields of a running vector, only counted while still pending
  always_comb begin
    for (int v = 0; v < NUM_VEC; v++) begin
      raise[v] = active_r[v] & pend[v] & (rank(field[v]) > rank(eff_r[v])); // RL5
    end
  end
  assign reentry_ev = |raise;

  // ****************************************
  // arbitration
  // ****************************************
  // fixed order: scanning down leaves the lowest vector on a tie
  always_comb begin
    win_req = 1'b0;
    win_vec = '0;
    win_lvl = LVL_3;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (pend[v] && rank(eff_r[v]) > rank(cc_r) &&
          (!win_req || rank(eff_r[v]) >= rank(win_lvl))) begin // RL16
        win_req = 1'b1;
        win_vec = VEC_W'(v);
        win_lvl = eff_r[v]; // RL2
      end
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  assign reject_ev = I_WR &&
    (((I_ADDR == OFF_PRIO0 || I_ADDR == OFF_PRIO1 || I_ADDR == OFF_PRIO2) &&
      has_reject(I_WDATA, 4)) || (I_ADDR == OFF_PRIO3 && has_reject(I_WDATA, 2)));

  // priority bytes; the top nibble of the last byte is fixed at ones
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      for (int r = 0; r < 4; r++) begin
        prio_r[r] <= PRIO_RST;
      end
    end else if (I_WR) begin
      for (int r = 0; r < 4; r++) begin
        if (I_ADDR == ADDR_W'(r)) begin
          prio_r[r] <= (r == 3) ? (merge(prio_r[r], I_WDATA) | PRIO3_RO_MASK)
                                : merge(prio_r[r], I_WDATA); // RL3
        end
      end
    end
  end

  // control and mask
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      warn_en_r <= 1'b0;
      mask_r    <= '0;
    end else if (I_WR) begin
      if (I_ADDR == OFF_CTRL) begin
        warn_en_r <= I_WDATA[CTRL_WARN_EN];
      end
      if (I_ADDR == OFF_MASK) begin
        mask_r <= I_WDATA[ST_W-1:0];
      end
    end
  end

  // ****************************************
  // supply warning
  // ****************************************
  // events before the reset delay ends mean a fast rise and are dropped
  assign delay_lim  = I_LONG_DELAY ? DELAY_LONG : DELAY_SHORT;
  assign delay_done = (dly_cnt_r >= delay_lim);
  assign warn_ev    = I_WARN_EVENT & delay_done; // RL12

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      dly_cnt_r <= '0;
    end else if (!delay_done) begin
      dly_cnt_r <= dly_cnt_r + 13'h0001;
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  // the warn flag stays pending so enabling later still raises it once
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      status_r <= '0;
    end else begin
      for (int b = 0; b < ST_W; b++) begin
        if (I_WR && I_ADDR == OFF_STATUS && I_WDATA[b]) begin
          status_r[b] <= 1'b0;
        end
      end
      if (warn_ev) begin
        status_r[ST_WARN] <= 1'b1; // RL13 RL14
      end
      if (reject_ev) begin
        status_r[ST_REJECT] <= 1'b1;
      end
      if (reentry_ev) begin
        status_r[ST_REENTRY] <= 1'b1;
      end
    end
  end

  assign O_IRQ = |(status_r & mask_r);

  // ****************************************
  // reset source capture
  // ****************************************
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      rst_src_r <= ZERO8;
    end else if (mode_r != HALTED) begin
      rst_src_r <= I_RST_SRC; // RL11
    end
  end

  // ****************************************
  // entry, return and nesting stack
  // ****************************************
  assign do_ack  = I_CORE_OP.ack & int_r.req;
  assign do_ret  = I_CORE_OP.interrupt_return_instr & (sp_r != '0);
  assign top_vec = stack_r[STACK_W'(sp_r - 1'b1)];

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      sp_r <= '0;
      for (int d = 0; d < STACK_D; d++) begin
        stack_r[d] <= '0;
      end
    end else if (do_ack && sp_r != (STACK_W+1)'(STACK_D)) begin
      stack_r[STACK_W'(sp_r)] <= int_r.vec;
      sp_r                    <= sp_r + 1'b1;
    end else if (do_ret) begin
      sp_r <= sp_r - 1'b1;
    end
  end

  // handler-active marks per vector
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      active_r <= '0;
    end else if (do_ack) begin
      active_r[int_r.vec] <= 1'b1;
    end else if (do_ret) begin
      active_r[top_vec] <= 1'b0;
    end
  end

  // active priority: tracks the field outside its handler, frozen inside unless raised while pending
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      for (int v = 0; v < NUM_VEC; v++) begin
        eff_r[v] <= LVL_3;
      end
    end else begin
      for (int v = 0; v < NUM_VEC; v++) begin
        if (!active_r[v] || raise[v]) begin
          eff_r[v] <= field[v]; // RL5 RL6
        end
      end
    end
  end

  // ****************************************
  // condition-code level bits
  // ****************************************
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      cc_r <= LVL_3; // RL4
    end else if (I_CORE_OP.trap) begin
      cc_r <= LVL_3; // RL4
    end else if (do_ack) begin
      cc_r <= int_r.level; // RL7
    end else if (I_CORE_OP.interrupt_return_instr || I_CORE_OP.pop) begin
      cc_r <= I_CORE_OP.pop_level; // RL7 RL8
    end else if (I_CORE_OP.sim) begin
      cc_r <= LVL_3; // RL8
    end else if (I_CORE_OP.interrupts_enable_instr || I_CORE_OP.halt || I_CORE_OP.wait_for_interrupt_instr) begin
      cc_r <= LVL_0; // RL8
    end
  end
  assign O_CC_LEVEL = cc_r;

  // ****************************************
  // power mode and wake-up
  // ****************************************
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      mode_r <= RUN;
    end else begin
      unique case (mode_r)
        RUN: begin
          if (I_CORE_OP.halt) begin
            mode_r <= HALTED;
          end else if (I_CORE_OP.wait_for_interrupt_instr) begin
            mode_r <= WAITING;
          end
        end
        WAITING: begin
          if (win_req) begin
            mode_r <= RUN; // RL10
          end
        end
        HALTED: begin
          if (|(I_IRQ & HALT_WAKE_MASK)) begin
            mode_r <= RUN; // RL15
          end
        end
      endcase
    end
  end

  // the warning flag is not a source here, so it cannot end halt
  assign O_WAKE = ((mode_r == WAITING) && win_req) ||
                  ((mode_r == HALTED) && |(I_IRQ & HALT_WAKE_MASK)); // RL10 RL15

  // ****************************************
  // request to the core
  // ****************************************
  // one cycle behind arbitration; cleared while an ack is taken
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      int_r <= '{req: 1'b0, vec: '0, level: LVL_3};
    end else begin
      int_r.req   <= win_req & ~do_ack & (mode_r != HALTED);
      int_r.vec   <= win_vec;
      int_r.level <= win_lvl;
    end
  end
  assign O_INT = int_r;

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      rdata_r <= ZERO8;
    end else if (I_RD) begin
      unique case (I_ADDR)
        OFF_PRIO0:  rdata_r <= prio_r[0];
        OFF_PRIO1:  rdata_r <= prio_r[1];
        OFF_PRIO2:  rdata_r <= prio_r[2];
        OFF_PRIO3:  rdata_r <= prio_r[3];
        OFF_CTRL:   rdata_r <= {7'h00, warn_en_r};
        OFF_STATUS: rdata_r <= {5'h00, status_r};
        OFF_MASK:   rdata_r <= {5'h00, mask_r};
        OFF_RSTSRC: rdata_r <= rst_src_r;
        OFF_STATE:  rdata_r <= {2'h0, mode_r, sp_r[1:0], cc_r};
        default:    rdata_r <= ZERO8;
      endcase
    end else begin
      rdata_r <= ZERO8;
    end
  end
  assign O_RDATA = rdata_r;

endmodule : int_prio_ctrl

// *** testbench/int_prio_checker.sv ***
// port assertions for the interrupt priority controller
`timescale 1ns/1ps
module int_prio_checker (
  input wire logic                            I_CLOCK,
  input wire logic                            I_RST_N,
  input wire logic [int_prio_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic                            I_RD,
  input wire logic [7:0]                      O_RDATA,
  input wire int_prio_pkg::core_op_t          I_CORE_OP,
  input wire int_prio_pkg::int_req_t          O_INT,
  input wire logic [1:0]                      O_CC_LEVEL
);
  import int_prio_pkg::*;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  logic take_w;
  logic calm_w;
  // an ack only counts while an offer stands; trap outranks it
  assign take_w = I_CORE_OP.ack && O_INT.req && !I_CORE_OP.trap;
  assign calm_w = !I_CORE_OP.trap && !(I_CORE_OP.ack && O_INT.req);
  // rank of a level code, level 0 lowest
  function automatic logic [1:0] rank_of(input logic [1:0] c);
    return {c[1] ~^ c[0], c[0]};
  endfunction : rank_of
  property p_rd_idle;
    !$past(I_RD) |-> O_RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  property p_prio3_ro;
    $past(I_RD) && $past(I_ADDR) == OFF_PRIO3 |-> O_RDATA[7:4] == 4'hF;
  endproperty
  a_prio3_ro: assert property (p_prio3_ro)
    else $error("upper nibble of last priority register not ones");
  property p_trap;
    I_CORE_OP.trap |=> O_CC_LEVEL == LVL_3;
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap left level below 3");
  property p_ack_lvl;
    take_w |=> O_CC_LEVEL == $past(O_INT.level);
  endproperty
  a_ack_lvl: assert property (p_ack_lvl)
    else $error("entry level differs from offered priority");
  property p_req_drop;
    I_CORE_OP.ack && O_INT.req |=> !O_INT.req;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("offer stands after ack");
  property p_above;
    O_INT.req |-> rank_of(O_INT.level) > rank_of($past(O_CC_LEVEL));
  endproperty
  a_above: assert property (p_above)
    else $error("offer not above current level");
  property p_pop;
    (I_CORE_OP.interrupt_return_instr || I_CORE_OP.pop) && calm_w |=> O_CC_LEVEL == $past(I_CORE_OP.pop_level);
  endproperty
  a_pop: assert property (p_pop)
    else $error("popped level not restored");
  property p_sim;
    I_CORE_OP.sim && calm_w && !I_CORE_OP.interrupt_return_instr && !I_CORE_OP.pop |=> O_CC_LEVEL == LVL_3;
  endproperty
  a_sim: assert property (p_sim)
    else $error("disable did not set level 3");
  property p_open;
    (I_CORE_OP.interrupts_enable_instr || I_CORE_OP.halt || I_CORE_OP.wait_for_interrupt_instr) && calm_w && !I_CORE_OP.sim
      && !I_CORE_OP.interrupt_return_instr && !I_CORE_OP.pop |=> O_CC_LEVEL == LVL_0;
  endproperty
  a_open: assert property (p_open)
    else $error("enable, halt or wait did not set level 0");
endmodule : int_prio_checker

// *** testbench/core_model.sv ***
// behavioural core that acknowledges interrupt offers
`timescale 1ns/1ps
module core_model (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   en,
  input  wire logic [3:0]             lag,
  input  wire int_prio_pkg::int_req_t req,
  input  wire int_prio_pkg::core_op_t cmd,
  output int_prio_pkg::core_op_t      op
);
  import int_prio_pkg::*;
  logic [3:0] cnt_r;
  logic       ack_r;
  // ack only after lag cycles, so the offer has to stand meanwhile
  always_ff @(posedge clk) begin
    if (!rst_n || !en || !req.req || ack_r) begin
      cnt_r <= 4'h0;
      ack_r <= 1'b0;
    end else if (cnt_r == lag) begin
      ack_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  // the bench supplies every other core operation
  always_comb begin
    op     = cmd;
    op.ack = ack_r;
  end
endmodule : core_model

// *** testbench/tb_int_prio_ctrl.sv ***
// self-checking bench for the interrupt priority controller
`timescale 1ns/1ps
module tb_int_prio_ctrl;
  import int_prio_pkg::*;
  localparam logic [9:0] RIM_OP = 10'h200, SIM_OP = 10'h100, HALT_OP = 10'h080;
  localparam logic [9:0] WFI_OP = 10'h040, INTERRUPT_RETURN_INSTR_OP = 10'h020, TRAP_OP = 10'h008;
  logic clk, rst_n, wr, rd, warn, long_dly, wake, irq_o, mdl_en;
  logic [ADDR_W-1:0]  addr;
  logic [7:0]         wdata, rdata, rst_src;
  logic [NUM_VEC-1:0] irq;
  logic [3:0]         lag;
  logic [1:0]         cc;
  core_op_t           cmd, op;
  int_req_t           req;
  int                 n_fail = 0, tests_run = 0, cyc = 0;
  int_prio_ctrl i_int_prio_ctrl (.I_CLOCK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_IRQ(irq),
    .I_WARN_EVENT(warn), .I_LONG_DELAY(long_dly), .I_RST_SRC(rst_src), .I_CORE_OP(op),
    .O_INT(req), .O_CC_LEVEL(cc), .O_WAKE(wake), .O_IRQ(irq_o));
  core_model i_core_model (.clk(clk), .rst_n(rst_n), .en(mdl_en), .lag(lag), .req(req),
    .cmd(cmd), .op(op));
  task automatic give_verdict();
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_cc(input logic [1:0] e);
    chk({6'h00, cc}, {6'h00, e});
  endtask : chk_cc
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_chk
  task automatic pulse(input logic [9:0] o);
    @(posedge clk);
    cmd <= o;
    @(posedge clk);
    cmd <= '0;
    #1;
  endtask : pulse
  // bounded waits on the offer rising and falling
  task automatic wait_req(input logic [3:0] v, input logic [1:0] l);
    int n;
    n = 0;
    while (req.req !== 1'b1 && n < 30) begin
      @(posedge clk);
      #1 n++;
    end
    chk({1'b0, req.req, req.level, req.vec}, {2'b01, l, v});
  endtask : wait_req
  task automatic wait_drop();
    int n;
    n = 0;
    while (req.req === 1'b1 && n < 30) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_drop
  task automatic s_regs();
    @(posedge clk);
    warn <= 1'b1;
    @(posedge clk);
    warn <= 1'b0;
    for (int i = 0; i < 4; i++) rd_chk(ADDR_W'(i), PRIO_RST);
    rd_chk(OFF_STATUS, ZERO8);
    rd_chk(4'hF, ZERO8);
    chk_cc(LVL_3);
  endtask : s_regs
  task automatic s_reject();
    wr_reg(OFF_PRIO0, 8'hCF);
    wr_reg(OFF_PRIO0, 8'h64);
    rd_chk(OFF_PRIO0, 8'h44);
    rd_chk(OFF_STATUS, 8'h02);
    wr_reg(OFF_STATUS, 8'h02);
    rd_chk(OFF_STATUS, ZERO8);
    wr_reg(OFF_PRIO3, ZERO8);
    rd_chk(OFF_PRIO3, PRIO3_RO_MASK);
  endtask : s_reject
  task automatic s_service();
    pulse(RIM_OP);
    chk_cc(LVL_0);
    @(posedge clk);
    irq    <= 14'h0008;
    mdl_en <= 1'b1;
    wait_req(4'h3, LVL_1);
    wait_drop();
    chk_cc(LVL_1);
    wr_reg(OFF_PRIO0, 8'h04);
    wait_req(4'h3, LVL_2);
    wait_drop();
    chk_cc(LVL_2);
    rd_chk(OFF_STATUS, 8'h04);
    wr_reg(OFF_STATUS, 8'h04);
    @(posedge clk);
    irq    <= '0;
    mdl_en <= 1'b0;
    pulse(INTERRUPT_RETURN_INSTR_OP | 10'(LVL_1));
    chk_cc(LVL_1);
    pulse(TRAP_OP);
    chk_cc(LVL_3);
    pulse(RIM_OP);
  endtask : s_service
  // equal priorities: lowest vector first, equal to level not served
  task automatic s_tie();
    @(posedge clk);
    irq <= 14'h000C;
    wait_req(4'h2, LVL_2);
    pulse(SIM_OP);
    chk_cc(LVL_3);
    @(posedge clk);
    #1 chk({7'h00, req.req}, ZERO8);
    pulse(RIM_OP);
    @(posedge clk);
    mdl_en <= 1'b1;
    wait_req(4'h2, LVL_2);
    wait_drop();
    @(posedge clk);
    #1 chk({7'h00, req.req}, ZERO8);
    @(posedge clk);
    mdl_en <= 1'b0;
    // lowering vector 2 inside its handler: it keeps its frozen level and still wins the tie
    wr_reg(OFF_PRIO0, 8'h14);
    pulse(RIM_OP);
    wait_req(4'h2, LVL_2);
    @(posedge clk);
    irq    <= '0;
    pulse(INTERRUPT_RETURN_INSTR_OP | 10'(LVL_0));
  endtask : s_tie
  task automatic s_warn();
    while (cyc < 320) @(posedge clk);
    wr_reg(OFF_MASK, 8'h01);
    warn <= 1'b1;
    @(posedge clk);
    warn <= 1'b0;
    rd_chk(OFF_STATUS, 8'h01);
    chk({7'h00, irq_o}, 8'h01);
    wr_reg(OFF_MASK, ZERO8);
    #1 chk({7'h00, irq_o}, ZERO8);
    wr_reg(OFF_MASK, 8'h01);
    wr_reg(OFF_CTRL, 8'h01);
    wait_req(WARN_VEC, LVL_1);
    pulse(SIM_OP);
    @(posedge clk);
    #1 chk({7'h00, req.req}, ZERO8);
    pulse(WFI_OP);
    chk({7'h00, wake}, 8'h01);
    wr_reg(OFF_STATUS, 8'h01);
    #1 chk({7'h00, irq_o}, ZERO8);
    // enabled before the crossing: the crossing itself gives a second warning
    @(posedge clk);
    warn <= 1'b1;
    @(posedge clk);
    warn <= 1'b0;
    wait_req(WARN_VEC, LVL_1);
  endtask : s_warn
  // second reset with long delay, then halt: vector 1 may not wake, vector 0 may
  task automatic s_halt();
    @(posedge clk);
    rst_n    <= 1'b0;
    long_dly <= 1'b1;
    irq      <= 14'h0002;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    pulse(HALT_OP);
    chk_cc(LVL_0);
    chk({7'h00, wake}, ZERO8);
    @(posedge clk);
    rst_src <= 8'hA5;
    irq     <= 14'h0003;
    // wake stands only until the next edge returns the mode to run
    #1 chk({7'h00, wake}, 8'h01);
    rd_chk(OFF_RSTSRC, 8'h5A);
    // past the short delay but inside the long one: crossing must be dropped
    repeat (300) @(posedge clk);
    warn <= 1'b1;
    @(posedge clk);
    warn <= 1'b0;
    rd_chk(OFF_STATUS, ZERO8);
  endtask : s_halt
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      $display("mismatch %0t run too long", $time);
      give_verdict();
    end
  end
  initial begin
    {rst_n, wr, rd, warn, long_dly, mdl_en} = '0;
    {addr, wdata, irq, cmd} = '0;
    rst_src = 8'h5A;
    lag     = 4'h4;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_reject();
    s_service();
    s_tie();
    s_warn();
    s_halt();
    give_verdict();
  end
endmodule : tb_int_prio_ctrl
bind int_prio_ctrl int_prio_checker i_int_prio_checker (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
  .I_ADDR(I_ADDR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CORE_OP(I_CORE_OP), .O_INT(O_INT),
  .O_CC_LEVEL(O_CC_LEVEL));
